// ===== hdl/ccr_pkg.sv
// Package for the card configuration register block.
// Assumes a single 25 MHz system clock; attribute strobes arrive asynchronously.
package ccr_pkg;
    // ************************************************************
    // Attribute space decode
    // ************************************************************
    localparam logic [8:0] CCR_OFS_OPTION    = 9'h000; // Option register
    localparam logic [8:0] CCR_OFS_STATUS    = 9'h002; // Config and status register
    localparam logic [8:0] CCR_OFS_PINREP    = 9'h004; // Pin replacement register
    localparam logic [8:0] CCR_OFS_SOCKET    = 9'h006; // Socket and copy register
    localparam logic [1:0] CCR_SPACE_CFG     = 2'h1;   // A10/A9 for config registers
    localparam logic [1:0] CCR_SPACE_IDENT   = 2'h0;   // A10/A9 for identity area
    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CCR_OPT_SRST   = 7; // Soft reset
    localparam int CCR_OPT_LEVEL  = 6; // Level interrupt select
    localparam int CCR_STS_CHG    = 7; // Changed flag
    localparam int CCR_STS_CHANGE_SIGNAL_ENABLE = 6; // Change signal enable
    localparam int CCR_STS_IO8    = 5; // Eight-bit I/O request
    localparam int CCR_STS_PL1D   = 4; // Power level 1 disable
    localparam int CCR_STS_AUDIO  = 3; // Audio enable
    localparam int CCR_STS_PWRDN  = 2; // Power down request
    localparam int CCR_STS_INT    = 1; // Interrupt request
    localparam int CCR_PR_CRDY    = 5; // Ready changed
    localparam int CCR_PR_CWP     = 4; // Write protect changed
    localparam int CCR_PR_RRDY    = 1; // Ready state / mask
    localparam int CCR_PR_WP      = 0; // Write protect state / mask
    localparam logic [7:0] CCR_ZERO8     = 8'h00; // Reset value of bytes
    localparam logic [7:0] CCR_PR_FIXED  = 8'h0C; // Pin replacement fixed ones
    localparam logic [5:0] CCR_IDX_MEM   = 6'h00; // Memory mapped index
    localparam logic [5:0] CCR_IDX_ANY   = 6'h01; // I/O any 16-byte boundary
    localparam logic [5:0] CCR_IDX_PRI   = 6'h02; // I/O primary range
    localparam logic [5:0] CCR_IDX_SEC   = 6'h03; // I/O secondary range
    localparam logic [5:0] CCR_IDX_RSV   = 6'h30; // Reserved upper index bits
    // ************************************************************
    // Power state machine
    // ************************************************************
    typedef enum logic [1:0] {
        CCR_PWR_ACTIVE = 2'b00,
        CCR_PWR_TO_LOW = 2'b01,
        CCR_PWR_LOW    = 2'b11,
        CCR_PWR_TO_ACT = 2'b10
    } ccr_pwr_type;
endpackage

// ===== hdl/ccr_card_config.sv
// Card configuration registers in attribute memory.
// Assumes host strobes are asynchronous and are held stable across the access.
`timescale 1ns/1ps
module ccr_card_config
    import ccr_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        hard_reset,
    input  wire logic        low_byte_card_enable_n,
    input  wire logic        high_byte_card_enable_n,
    input  wire logic        reg_select_n,
    input  wire logic        output_enable_n,
    input  wire logic        write_enable_n,
    input  wire logic [10:0] addr,
    input  wire logic [15:0] data_in,
    output logic      [15:0] data_out,
    output logic      [15:0] data_oe,
    input  wire logic        ident_data_valid,
    input  wire logic [7:0]  ident_byte,
    output logic      [8:0]  ident_addr,
    input  wire logic        drive_ready,
    input  wire logic        drive_irq,
    input  wire logic        drive_interrupt_disable,
    input  wire logic        drive_idle,
    input  wire logic        drive_command,
    input  wire logic        power_ack,
    output logic             status_change_pin,
    output logic             card_reset,
    output logic             level_irq_select,
    output logic      [5:0]  config_index,
    output logic             io_configured,
    output logic             power_low,
    output logic             ready_out
);
    // ************************************************************
    // Pin input synchronisers
    // ************************************************************
    localparam int NSYNC = 5; // Strobe lines synchronised
    logic [NSYNC-1:0] pin_raw;   // Raw strobes
    logic [NSYNC-1:0] pin_s1_q;  // First stage
    logic [NSYNC-1:0] pin_s2_q;  // Second stage
    logic [NSYNC-1:0] pin_s3_q;  // Third stage
    logic [NSYNC-1:0] pin_q;     // Accepted level
    assign pin_raw = {low_byte_card_enable_n, high_byte_card_enable_n, reg_select_n,
                      output_enable_n, write_enable_n};
    // One three-stage chain per strobe
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge sys_clk) begin
                if (!rst_b) begin
                    pin_s1_q[gi] <= 1'b1;
                    pin_s2_q[gi] <= 1'b1;
                    pin_s3_q[gi] <= 1'b1;
                    pin_q[gi]    <= 1'b1;
                end else begin
                    pin_s1_q[gi] <= pin_raw[gi];
                    pin_s2_q[gi] <= pin_s1_q[gi];
                    pin_s3_q[gi] <= pin_s2_q[gi];
                    // Accept only when second and third agree
                    if (pin_s2_q[gi] == pin_s3_q[gi]) begin
                        pin_q[gi] <= pin_s3_q[gi];
                    end
                end
            end
        end
    endgenerate
    logic ce1_n, ce2_n, reg_n, oe_n, we_n; // Clean strobes
    assign {ce1_n, ce2_n, reg_n, oe_n, we_n} = pin_q;

    // ************************************************************
    // Address decode
    // ************************************************************
    logic attr_sel;   // Attribute space, even byte
    logic cfg_sel;    // Config register window
    logic ident_sel;  // Identity structure window
    logic sel_opt, sel_sts, sel_pr, sel_sc; // Register selects
    logic we_q;       // Delayed write strobe for edge
    logic wr_pulse;   // One cycle at write strobe rise
    // Even byte only; odd attribute cycles select nothing
    assign attr_sel  = !reg_n && !ce1_n && !addr[0];
    assign cfg_sel   = attr_sel && (addr[10:9] == CCR_SPACE_CFG);
    assign ident_sel = attr_sel && (addr[10:9] == CCR_SPACE_IDENT);
    assign sel_opt   = cfg_sel && (addr[8:0] == CCR_OFS_OPTION);
    assign sel_sts   = cfg_sel && (addr[8:0] == CCR_OFS_STATUS);
    assign sel_pr    = cfg_sel && (addr[8:0] == CCR_OFS_PINREP);
    assign sel_sc    = cfg_sel && (addr[8:0] == CCR_OFS_SOCKET);
    assign ident_addr = addr[8:0];
    // Writes take effect at the trailing edge of the write strobe
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            we_q <= 1'b1;
        end else begin
            we_q <= we_n;
        end
    end
    assign wr_pulse = !we_q && we_n && oe_n;

    // ************************************************************
    // Option register and soft reset
    // ************************************************************
    logic       srst_q;   // Soft reset bit
    logic       level_q;  // Level interrupt select
    logic [5:0] index_q;  // Configuration index
    logic       int_rst;  // Combined internal reset
    // Hardware reset clears all; soft reset clears all but itself
    assign int_rst    = hard_reset || srst_q;
    assign card_reset = int_rst;
    always_ff @(posedge sys_clk) begin
        if (!rst_b || hard_reset) begin
            srst_q <= 1'b0;
        end else if (wr_pulse && sel_opt) begin
            srst_q <= data_in[CCR_OPT_SRST];
        end
    end
    // Other fields stay clear while reset is held
    always_ff @(posedge sys_clk) begin
        if (!rst_b || int_rst) begin
            level_q <= 1'b0;
            index_q <= CCR_IDX_MEM;
        end else if (wr_pulse && sel_opt) begin
            level_q <= data_in[CCR_OPT_LEVEL];
            index_q <= data_in[5:0];
        end
    end
    assign level_irq_select = level_q;
    assign config_index     = index_q;
    // Index 1, 2 or 3 means the card is on the I/O interface
    assign io_configured = (index_q == CCR_IDX_ANY) || (index_q == CCR_IDX_PRI)
                        || (index_q == CCR_IDX_SEC);

    // ************************************************************
    // Pin replacement changed bits
    // ************************************************************
    logic crdy_q, cwp_q;   // Changed bits
    logic rdy_prev_q;      // Previous ready state
    logic rdy_state;       // Internal ready state
    logic changed;         // Changed flag
    assign changed = crdy_q || cwp_q;
    // Hardware set wins over a host clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_b || int_rst) begin
            crdy_q     <= 1'b0;
            cwp_q      <= 1'b0;
            rdy_prev_q <= 1'b1;
        end else begin
            rdy_prev_q <= rdy_state;
            if (rdy_state != rdy_prev_q) begin
                crdy_q <= 1'b1;
            end else if (wr_pulse && sel_pr && data_in[CCR_PR_RRDY]) begin
                crdy_q <= data_in[CCR_PR_CRDY];
            end
            // Write protect never changes, so only host writes apply
            if (wr_pulse && sel_pr && data_in[CCR_PR_WP]) begin
                cwp_q <= data_in[CCR_PR_CWP];
            end
        end
    end

    // ************************************************************
    // Config and status register
    // ************************************************************
    logic change_signal_enable_q, io8_q, audio_q, pwrdn_q; // Writable status bits
    logic pl1d;            // Power level 1 disable, unsupported
    logic int_bit;         // Interrupt status
    assign pl1d = 1'b0;
    always_ff @(posedge sys_clk) begin
        if (!rst_b || int_rst) begin
            change_signal_enable_q <= 1'b0;
            io8_q    <= 1'b0;
            audio_q  <= 1'b0;
            pwrdn_q  <= 1'b0;
        end else if (wr_pulse && sel_sts) begin
            // Bits 7, 4, 1 and 0 are not stored
            change_signal_enable_q <= data_in[CCR_STS_CHANGE_SIGNAL_ENABLE];
            io8_q    <= data_in[CCR_STS_IO8];
            audio_q  <= data_in[CCR_STS_AUDIO];
            pwrdn_q  <= data_in[CCR_STS_PWRDN];
        end
    end
    assign int_bit = drive_irq && !drive_interrupt_disable;
    // Open-drain style change pin, low only when enabled in I/O mode
    assign status_change_pin = !(io_configured && change_signal_enable_q && changed);

    // ************************************************************
    // Power state and ready
    // ************************************************************
    ccr_pwr_type pwr_q;    // Power state
    logic        auto_low; // Automatic idle power down
    always_ff @(posedge sys_clk) begin
        if (!rst_b || int_rst) begin
            pwr_q <= CCR_PWR_ACTIVE;
        end else begin
            case (pwr_q)
                CCR_PWR_ACTIVE: begin
                    if (pwrdn_q) begin
                        pwr_q <= CCR_PWR_TO_LOW;
                    end
                end
                CCR_PWR_TO_LOW: begin
                    if (power_ack) begin
                        pwr_q <= CCR_PWR_LOW;
                    end
                end
                CCR_PWR_LOW: begin
                    if (!pwrdn_q) begin
                        pwr_q <= CCR_PWR_TO_ACT;
                    end
                end
                CCR_PWR_TO_ACT: begin
                    if (power_ack) begin
                        pwr_q <= CCR_PWR_ACTIVE;
                    end
                end
                default: pwr_q <= CCR_PWR_ACTIVE;
            endcase
        end
    end
    // Idle power down runs on its own, a command wakes it
    always_ff @(posedge sys_clk) begin
        if (!rst_b || int_rst) begin
            auto_low <= 1'b0;
        end else if (drive_command) begin
            auto_low <= 1'b0;
        end else if (drive_idle) begin
            auto_low <= 1'b1;
        end
    end
    assign power_low = (pwr_q != CCR_PWR_ACTIVE) || auto_low;
    // Busy while in a power transition or a request not yet acted on
    assign rdy_state = drive_ready && !int_rst
                    && (pwr_q != CCR_PWR_TO_LOW) && (pwr_q != CCR_PWR_TO_ACT)
                    && !(pwrdn_q && (pwr_q == CCR_PWR_ACTIVE))
                    && !(!pwrdn_q && (pwr_q == CCR_PWR_LOW));
    assign ready_out = rdy_state;

    // ************************************************************
    // Read data path
    // ************************************************************
    logic [7:0] rd_d;      // Selected read byte
    logic [7:0] rd_q;      // Registered read byte
    logic       rd_en;     // Read cycle active
    always_comb begin
        rd_d = CCR_ZERO8;
        if (sel_opt) begin
            rd_d = {srst_q, level_q, index_q};
        end else if (sel_sts) begin
            rd_d = {changed, change_signal_enable_q, io8_q, pl1d, audio_q, pwrdn_q, int_bit, 1'b0};
        end else if (sel_pr) begin
            rd_d = CCR_PR_FIXED | {2'b00, crdy_q, cwp_q, 2'b00, rdy_state, 1'b0};
        end else if (ident_sel && ident_data_valid) begin
            rd_d = ident_byte;
        end
    end
    assign rd_en = attr_sel && !oe_n && we_n && (cfg_sel || ident_sel);
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rd_q <= CCR_ZERO8;
        end else begin
            rd_q <= rd_d;
        end
    end
    // Only the low lanes are driven in attribute space
    assign data_out = {CCR_ZERO8, rd_q};
    assign data_oe  = {CCR_ZERO8, {8{rd_en}}};

    // ************************************************************
    // Assertions
    // ************************************************************
    soft_rst_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        srst_q |=> (index_q == CCR_IDX_MEM) && !level_q)
        else $error("config not held clear under soft reset");
    hard_rst_clr_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        hard_reset |=> !srst_q)
        else $error("soft reset bit survived hard reset");
    changed_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (crdy_q || cwp_q) |-> changed)
        else $error("changed flag missing");
    status_change_pin_low_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !change_signal_enable_q |-> status_change_pin)
        else $error("change pin low while disabled");
    pl1_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (wr_pulse && sel_sts) |=> !pl1d)
        else $error("power level 1 disable set");
    pwr_busy_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ($changed(pwrdn_q) && !int_rst) |-> !ready_out)
        else $error("ready during power change");
    int_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        drive_interrupt_disable |-> !int_bit)
        else $error("interrupt status set while disabled");
    rdy_change_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ($changed(rdy_state) && !int_rst && !$past(int_rst)) |=> crdy_q)
        else $error("ready change not flagged");
    upper_lane_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        data_oe[15:8] == CCR_ZERO8)
        else $error("upper lanes driven");
    ident_wr_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (wr_pulse && ident_sel) |=> $stable(index_q))
        else $error("identity write altered config");
    // Soft reset bit holds itself while the rest of the block sits in reset
    soft_bit_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (srst_q && !hard_reset && !(wr_pulse && sel_opt)) |=> srst_q)
        else $error("soft reset bit cleared itself");
    hard_rst_cfg_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        hard_reset |=> (index_q == CCR_IDX_MEM) && !level_q)
        else $error("option fields kept through hard reset");
    sts_fixed_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        sel_sts |=> !rd_q[0] && !rd_q[CCR_STS_PL1D])
        else $error("fixed status bits read one");
    odd_wr_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (wr_pulse && addr[0] && !int_rst) |=> $stable(index_q) && $stable(change_signal_enable_q))
        else $error("odd attribute write took effect");
    status_change_pin_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (io_configured && change_signal_enable_q && changed) |-> !status_change_pin)
        else $error("change pin not driven low");
endmodule

// ===== sim/ccr_host_model.sv
// Host socket model: drives the attribute strobes, address and write data.
// Assumes the card samples the strobes through synchronisers on sys_clk.
`timescale 1ns/1ps
module ccr_host_model (
    input  wire logic        sys_clk,
    input  wire logic [15:0] rdata,
    input  wire logic [15:0] roe,
    output logic             ce1_n,
    output logic             ce2_n,
    output logic             reg_n,
    output logic             oe_n,
    output logic             we_n,
    output logic      [10:0] addr,
    output logic      [15:0] wdata
);
    // ************************************************************
    // Attribute bus cycles
    // ************************************************************
    // Strobes idle high; lanes carry a pattern that is never valid
    initial begin
        {ce1_n, ce2_n, reg_n, oe_n, we_n} = 5'h1F;
        addr = 11'h000;
        wdata = 16'h5AA5;
    end
    // Let a number of clock edges pass
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // Select the card with the chosen lane width
    task automatic open_cyc(input logic [10:0] a, input logic wide);
        @(posedge sys_clk);
        addr  <= a;
        ce1_n <= 1'b0;
        ce2_n <= ~wide;
        reg_n <= 1'b0;
    endtask
    // Hold, release, then invert the lanes so stale data cannot match
    task automatic close_cyc();
        idle(6);
        {ce1_n, ce2_n, reg_n} <= 3'h7;
        wdata <= ~wdata;
        idle(6);
    endtask
    // Byte write; upper lanes carry junk that the card must ignore
    task automatic wr(input logic [10:0] a, input logic [7:0] d, input logic wide);
        logic [7:0] v;
        v = d;
        if (a == 11'h200) v[5:4] = 2'h0;
        if (a == 11'h202) v[3] = 1'b0;
        open_cyc(a, wide);
        wdata <= {~v, v};
        we_n  <= 1'b0;
        idle(8);
        we_n <= 1'b1;
        close_cyc();
    endtask
    // Byte read; data taken mid-cycle while the strobes still stand
    task automatic rd(input logic [10:0] a, input logic wide, output logic [15:0] d, output logic [15:0] e);
        open_cyc(a, wide);
        oe_n <= 1'b0;
        idle(8);
        @(negedge sys_clk);
        d = rdata;
        e = roe;
        @(posedge sys_clk);
        oe_n <= 1'b1;
        close_cyc();
    endtask
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the card configuration registers.
// Assumes ccr_host_model plays the socket controller on the attribute bus.
`timescale 1ns/1ps
module testbench;
    import ccr_pkg::*;
    // ************************************************************
    // Clock, reset, drive-side inputs and counters
    // ************************************************************
    logic        sys_clk = 1'b0, rst_b = 1'b0, hard_reset = 1'b0, id_valid = 1'b1;
    logic [7:0]  id_byte = 8'h00;
    logic        drv_rdy = 1'b1, drv_irq = 1'b0, irq_dis = 1'b0, drv_idle = 1'b0, drv_cmd = 1'b0, pwr_ack = 1'b0;
    logic        ce1_n, ce2_n, reg_n, oe_n, we_n, status_change_pin_n, card_reset, lvl, io_cfg, pwr_low, rdy;
    logic [10:0] addr;
    logic [15:0] wdata, rdata, roe;
    logic [5:0]  cidx;
    logic [8:0]  id_addr;
    logic [10:0] bad [4] = '{11'h000, 11'h201, 11'h600, 11'h010};
    int          num_errors = 0, n_tests = 0, cyc = 0;
    // Free-running system clock
    always #20 sys_clk = ~sys_clk;
    ccr_host_model host_u (.sys_clk, .rdata, .roe, .ce1_n, .ce2_n, .reg_n, .oe_n, .we_n, .addr, .wdata);
    ccr_card_config dut_u (.sys_clk, .rst_b, .hard_reset, .low_byte_card_enable_n(ce1_n),
        .high_byte_card_enable_n(ce2_n), .reg_select_n(reg_n), .output_enable_n(oe_n), .write_enable_n(we_n),
        .addr, .data_in(wdata), .data_out(rdata), .data_oe(roe), .ident_data_valid(id_valid),
        .ident_byte(id_byte), .ident_addr(id_addr), .drive_ready(drv_rdy), .drive_irq(drv_irq),
        .drive_interrupt_disable(irq_dis), .drive_idle(drv_idle), .drive_command(drv_cmd), .power_ack(pwr_ack),
        .status_change_pin(status_change_pin_n), .card_reset, .level_irq_select(lvl), .config_index(cidx),
        .io_configured(io_cfg), .power_low(pwr_low), .ready_out(rdy));
    // ************************************************************
    // Checking helpers
    // ************************************************************
    // Compare after the edge has settled
    task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
        #1;
        n_tests++;
        if (g !== x) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, x, g);
        end
    endtask
    // Status byte from written value, interrupt and changed state
    function automatic logic [7:0] exp_sts(input logic [7:0] w, input logic irq, input logic chg);
        exp_sts = (w & 8'h64) | {chg, 5'h00, irq, 1'b0};
    endfunction
    // Pin replacement byte with ready high and no write protect
    function automatic logic [7:0] exp_pr(input logic crdy);
        exp_pr = CCR_PR_FIXED | 8'h02 | {2'h0, crdy, 5'h00};
    endfunction
    // One-cycle power acknowledge from the drive side
    task automatic ack();
        @(posedge sys_clk);
        pwr_ack <= 1'b1;
        @(posedge sys_clk);
        pwr_ack <= 1'b0;
        host_u.idle(4);
    endtask
    // Final report and end of run
    task automatic give_verdict();
        if (num_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Cut a hang short
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            give_verdict();
        end
    end
    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        logic [15:0] d, e;
        logic [7:0]  v;
        logic [10:0] a;
        v = 8'($urandom(32'h0E23FE5A));
        host_u.idle(2);
        rst_b <= 1'b1;
        host_u.idle(6);
        // Reset contents
        host_u.rd(11'h200, 1'b0, d, e);
        chk("option", 16'h0000, d);
        host_u.rd(11'h202, 1'b1, d, e);
        chk("status", 16'h0000, d);
        // Option register, indices 0 to 3 twice each with random level select
        for (int i = 0; i < 8; i++) begin
            v = {1'b0, 1'($urandom), 4'h0, 2'(i)};
            host_u.wr(11'h200, v, 1'($urandom));
            host_u.rd(11'h200, 1'($urandom), d, e);
            chk("option", {8'h00, v}, d);
            chk("index", {10'h0, v[5:0]}, {10'h0, cidx});
            chk("level", {15'h0, v[6]}, {15'h0, lvl});
            chk("io", {15'h0, v[1:0] != 2'h0}, {15'h0, io_cfg});
        end
        // Status register with read-only bits 7, 1 and 0 written high
        for (int i = 0; i < 6; i++) begin
            v = 8'($urandom) & 8'hFB | 8'h83;
            host_u.wr(11'h202, v, 1'($urandom));
            host_u.rd(11'h202, 1'b0, d, e);
            chk("status", {8'h00, exp_sts(v, 1'b0, 1'b0)}, d);
        end
        // Power-down request and return, busy until acknowledged
        for (int i = 1; i >= 0; i--) begin
            host_u.wr(11'h202, i ? 8'h04 : 8'h00, 1'b0);
            chk("ready", 16'h0000, {15'h0, rdy});
            ack();
            chk("ready", 16'h0001, {15'h0, rdy});
            chk("pwr_low", 16'(i), {15'h0, pwr_low});
        end
        // Automatic power down when idle, wake on command
        @(posedge sys_clk);
        drv_idle <= 1'b1;
        ack();
        chk("auto_low", 16'h0001, {15'h0, pwr_low});
        @(posedge sys_clk);
        drv_idle <= 1'b0;
        drv_cmd  <= 1'b1;
        @(posedge sys_clk);
        drv_cmd <= 1'b0;
        ack();
        chk("auto_low", 16'h0000, {15'h0, pwr_low});
        // Interrupt status: off, raised, raised but disabled
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk);
            drv_irq <= i != 0;
            irq_dis <= i == 2;
            host_u.rd(11'h202, 1'b0, d, e);
            chk("int", {15'h0, i == 1}, {15'h0, d[CCR_STS_INT]});
        end
        // Ready change, changed flag and status change pin
        @(posedge sys_clk);
        drv_irq <= 1'b0;
        irq_dis <= 1'b0;
        host_u.wr(11'h204, 8'h03, 1'b0);
        host_u.wr(11'h200, 8'h01, 1'b0);
        host_u.wr(11'h202, 8'h40, 1'b0);
        @(posedge sys_clk);
        drv_rdy <= 1'b0;
        host_u.idle(3);
        drv_rdy <= 1'b1;
        host_u.idle(3);
        host_u.rd(11'h204, 1'b0, d, e);
        chk("pinrep", {8'h00, exp_pr(1'b1)}, d);
        host_u.rd(11'h202, 1'b0, d, e);
        chk("status", {8'h00, exp_sts(8'h40, 1'b0, 1'b1)}, d);
        chk("status_change_pin", 16'h0000, {15'h0, status_change_pin_n});
        host_u.wr(11'h204, 8'h02, 1'b0);
        host_u.rd(11'h204, 1'b1, d, e);
        chk("pinrep", {8'h00, exp_pr(1'b0)}, d);
        chk("status_change_pin", 16'h0001, {15'h0, status_change_pin_n});
        host_u.wr(11'h204, 8'h22, 1'b0);
        chk("status_change_pin", 16'h0000, {15'h0, status_change_pin_n});
        host_u.wr(11'h202, 8'h00, 1'b0);
        chk("status_change_pin", 16'h0001, {15'h0, status_change_pin_n});
        host_u.rd(11'h206, 1'b0, d, e);
        chk("socket", 16'h0000, d);
        // Writes outside the register decode are dropped
        for (int i = 0; i < 4; i++) begin
            host_u.wr(bad[i], 8'h42, 1'b0);
        end
        host_u.rd(11'h200, 1'b0, d, e);
        chk("option", 16'h0001, d);
        host_u.rd(11'h201, 1'b0, d, e);
        chk("odd_oe", 16'h0000, e);
        // Identity read as a word: even byte on low lanes, blank when not valid
        for (int i = 0; i < 2; i++) begin
            a = {2'h0, 8'($urandom), 1'b0};
            @(posedge sys_clk);
            id_byte  <= 8'($urandom);
            id_valid <= i[0];
            host_u.rd(a, 1'b1, d, e);
            chk("ident", {8'h00, i[0] ? id_byte : 8'h00}, d);
            chk("lanes", 16'h00FF, e);
            chk("ident_addr", {7'h0, a[8:0]}, {7'h0, id_addr});
        end
        // Soft reset: bit kept, everything else cleared
        host_u.wr(11'h202, 8'h60, 1'b0);
        host_u.wr(11'h200, 8'hC3, 1'b0);
        host_u.rd(11'h200, 1'b0, d, e);
        chk("option", 16'h0080, d);
        chk("card_reset", 16'h0001, {15'h0, card_reset});
        host_u.wr(11'h200, 8'h00, 1'b0);
        host_u.rd(11'h202, 1'b0, d, e);
        chk("status", 16'h0000, d & 16'h007E);
        chk("card_reset", 16'h0000, {15'h0, card_reset});
        // Hardware reset pin clears the option register
        host_u.wr(11'h200, 8'hC1, 1'b0);
        @(posedge sys_clk);
        hard_reset <= 1'b1;
        host_u.idle(1);
        chk("card_reset", 16'h0001, {15'h0, card_reset});
        @(posedge sys_clk);
        hard_reset <= 1'b0;
        host_u.rd(11'h200, 1'b0, d, e);
        chk("option", 16'h0000, d);
        chk("card_reset", 16'h0000, {15'h0, card_reset});
        give_verdict();
    end
endmodule
